/* design/acr_result_store.sv */
/*
 Four result bytes, filled in order by the converter core.
 Assumes the core presents one result per write pulse; no reset touches
 the storage so cold power-up leaves it undefined and warm reset keeps it.
*/
`timescale 1ns/10ps
module acr_result_store (
    // Clock
    input  wire logic       clock,
    // Write side
    input  wire logic       wr_en,
    input  wire logic [1:0] wr_slot,
    input  wire logic [7:0] wr_data,
    // Read side
    input  wire logic [1:0] rd_slot,
    output logic      [7:0] rd_data
);
    logic [7:0] mem [0:acr_pkg::RESULT_COUNT-1];

    // Storage without reset, read with no side effect
    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_slot] <= wr_data;
        end
    end

    assign rd_data = mem[rd_slot];
endmodule

/* design/acr_top.sv */
/*
 Converter result registers and shared analog/digital pin control.
 Assumes the converter core runs the sequencing and reports results,
 completion, buffer-full, busy and overflow; bus accesses are one cycle.
 Result bytes carry no reset, so neither reset disturbs them.
*/
// What this block does
// - Four read-only result bytes, filled first to fourth in order.
// - Results count as valid only once end-of-conversion is set.
// - Cold reset leaves result bytes undefined.
// - Warm pin reset leaves result bytes unchanged.
// - Internal reference is off whenever the converter is disabled.
// - Each shared pin is digital or analog by its own select bit.
// - Digital input buffers blocked unless port is read, and in idle.
// - End-of-conversion sets on completion or full; raises enabled level interrupt.
// - Disabling terminates conversion and clears done, busy, overflow and the result slot.
`timescale 1ns/10ps
module acr_top (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       reset,
    // Peripheral bus
    input  wire logic [3:0] bus_addr,
    input  wire logic       bus_rd,
    input  wire logic       bus_wr,
    input  wire logic [7:0] bus_wdata,
    output logic      [7:0] bus_rdata,
    // Converter core
    input  wire logic       core_result_valid,
    input  wire logic [7:0] core_result,
    input  wire logic       core_done,
    input  wire logic       core_buffer_full,
    input  wire logic       core_busy,
    input  wire logic       core_overflow,
    output logic            core_abort,
    output logic      [2:0] sample_delay_sel,
    // Chip state and pins
    input  wire logic       idle_mode,
    input  wire logic [7:0] digital_port_inputs,
    output logic      [7:0] analog_inputs_select,
    output logic      [7:0] input_buffer_enable,
    output logic            internal_ref_on,
    output logic            irq
);
    logic [7:0] ctl1_reg, ctl1_next;
    logic [7:0] ctl3_reg, ctl3_next;
    logic [7:0] pinsel_reg, pinsel_next;
    logic       eoc_reg, eoc_next;
    logic       busy_reg, busy_next;
    logic       ovf_reg, ovf_next;
    logic [1:0] slot_reg, slot_next;
    logic [7:0] rdata_reg, rdata_next;
    logic       abort_reg, abort_next;
    logic       ref_reg, ref_next;
    logic       irq_reg, irq_next;
    logic [7:0] bufen_reg, bufen_next;
    logic [7:0] pin_s1_reg, pin_s2_reg;
    logic [7:0] pin_s1_next, pin_s2_next;
    logic [7:0] res_rdata;
    logic       enable_now;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        return a == off;
    endfunction

    // Analog-selected pins read back as zero on the port
    function automatic logic [7:0] port_view(input logic [7:0] pins, input logic [7:0] sel);
        return pins & ~sel;
    endfunction

    acr_result_store u_store (
        .clock   (clock),
        .wr_en   (core_result_valid & ctl1_reg[acr_pkg::CTL1_ENABLE_BIT]),
        .wr_slot (slot_reg),
        .wr_data (core_result),
        .rd_slot (bus_addr[1:0]),
        .rd_data (res_rdata)
    );

    // Pin synchroniser: logic reads only the second stage
    always_comb begin
        pin_s1_next = digital_port_inputs;
        pin_s2_next = pin_s1_reg;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            pin_s1_reg <= 8'h00;
            pin_s2_reg <= 8'h00;
        end else begin
            pin_s1_reg <= pin_s1_next;
            pin_s2_reg <= pin_s2_next;
        end
    end

    // Control registers keep only their writable bits
    always_comb begin
        ctl1_next   = ctl1_reg;
        ctl3_next   = ctl3_reg;
        pinsel_next = pinsel_reg;
        if (bus_wr && hit(bus_addr, acr_pkg::OFF_CONTROL_1)) begin
            ctl1_next = bus_wdata & acr_pkg::CTL1_WRITE_MASK;
        end
        if (bus_wr && hit(bus_addr, acr_pkg::OFF_CONTROL_3)) begin
            ctl3_next = bus_wdata & acr_pkg::CTL3_WRITE_MASK;
        end
        if (bus_wr && hit(bus_addr, acr_pkg::OFF_PIN_SELECT)) begin
            pinsel_next = bus_wdata;
        end
        enable_now  = ctl1_next[acr_pkg::CTL1_ENABLE_BIT];
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            ctl1_reg   <= acr_pkg::CTL1_RESET;
            ctl3_reg   <= acr_pkg::CTL3_RESET;
            pinsel_reg <= acr_pkg::PIN_SEL_RESET;
        end else begin
            ctl1_reg   <= ctl1_next;
            ctl3_reg   <= ctl3_next;
            pinsel_reg <= pinsel_next;
        end
    end

    // Converter state; a disable beats a same-cycle completion
    always_comb begin
        eoc_next   = eoc_reg;
        busy_next  = core_busy;
        ovf_next   = ovf_reg | core_overflow;
        slot_next  = slot_reg;
        abort_next = 1'b0;
        // Results fill in order, wrapping after the fourth
        if (core_result_valid && ctl1_reg[acr_pkg::CTL1_ENABLE_BIT]) begin
            slot_next = slot_reg + 2'd1;
        end
        if (core_done || core_buffer_full) begin
            eoc_next = 1'b1;
        end
        if (!enable_now) begin
            eoc_next   = 1'b0;
            busy_next  = 1'b0;
            ovf_next   = 1'b0;
            slot_next  = 2'd0;
            abort_next = 1'b1;
        end
        ref_next = enable_now & ctl1_next[acr_pkg::CTL1_REFSEL_BIT];
        irq_next = eoc_next & ctl1_next[acr_pkg::CTL1_IRQEN_BIT];
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            eoc_reg   <= 1'b0;
            busy_reg  <= 1'b0;
            ovf_reg   <= 1'b0;
            slot_reg  <= 2'd0;
            abort_reg <= 1'b1;
            ref_reg   <= 1'b0;
            irq_reg   <= 1'b0;
        end else begin
            eoc_reg   <= eoc_next;
            busy_reg  <= busy_next;
            ovf_reg   <= ovf_next;
            slot_reg  <= slot_next;
            abort_reg <= abort_next;
            ref_reg   <= ref_next;
            irq_reg   <= irq_next;
        end
    end

    // Read data stands for one cycle, zero when no read
    always_comb begin
        rdata_next = acr_pkg::READ_UNMAPPED;
        if (bus_rd) begin
            unique case (bus_addr)
                acr_pkg::OFF_RESULT_0,
                acr_pkg::OFF_RESULT_1,
                acr_pkg::OFF_RESULT_2,
                acr_pkg::OFF_RESULT_3:   rdata_next = res_rdata;
                acr_pkg::OFF_STATUS:     rdata_next = {5'h00, ovf_reg, busy_reg, eoc_reg};
                acr_pkg::OFF_CONTROL_1:  rdata_next = ctl1_reg;
                acr_pkg::OFF_CONTROL_3:  rdata_next = ctl3_reg;
                acr_pkg::OFF_PIN_SELECT: rdata_next = pinsel_reg;
                acr_pkg::OFF_PORT_DATA:  rdata_next = port_view(pin_s2_reg, pinsel_reg);
                default:                 rdata_next = acr_pkg::READ_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // Buffers open only after a port read outside idle, on digital pins
    always_comb begin
        bufen_next = 8'h00;
        if (bus_rd && hit(bus_addr, acr_pkg::OFF_PORT_DATA) && !idle_mode) begin
            bufen_next = ~pinsel_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            bufen_reg <= 8'h00;
        end else begin
            bufen_reg <= bufen_next;
        end
    end

    assign bus_rdata            = rdata_reg;
    assign core_abort           = abort_reg;
    assign sample_delay_sel     = ctl3_reg[acr_pkg::CTL3_DELAY_LSB +: 3];
    assign analog_inputs_select = pinsel_reg;
    assign input_buffer_enable  = bufen_reg;
    assign internal_ref_on      = ref_reg;
    assign irq                  = irq_reg;
endmodule

/* pkg/acr_pkg.sv */
/*
 Shared constants for the converter result store and shared-pin control.
 Assumes a byte-wide peripheral bus with a small register index decode.
*/
package acr_pkg;
    localparam int RESULT_COUNT = 4;
    localparam int PIN_COUNT    = 8;

    // Register indices on the peripheral bus (byte registers)
    localparam logic [3:0] OFF_RESULT_0   = 4'h0;
    localparam logic [3:0] OFF_RESULT_1   = 4'h1;
    localparam logic [3:0] OFF_RESULT_2   = 4'h2;
    localparam logic [3:0] OFF_RESULT_3   = 4'h3;
    localparam logic [3:0] OFF_STATUS     = 4'h4;
    localparam logic [3:0] OFF_CONTROL_1  = 4'h5;
    localparam logic [3:0] OFF_CONTROL_3  = 4'h6;
    localparam logic [3:0] OFF_PIN_SELECT = 4'h7;
    localparam logic [3:0] OFF_PORT_DATA  = 4'h8;

    // Control 1 fields
    localparam int CTL1_ENABLE_BIT = 0;
    localparam int CTL1_REFSEL_BIT = 1;
    localparam int CTL1_IRQEN_BIT  = 2;
    localparam logic [7:0] CTL1_WRITE_MASK = 8'h07;

    // Control 3 fields
    localparam int CTL3_DELAY_LSB = 3;
    localparam logic [7:0] CTL3_WRITE_MASK = 8'h3f;

    // Status fields
    localparam int STAT_EOC_BIT  = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_OVF_BIT  = 2;

    // Reset values
    localparam logic [7:0] CTL1_RESET      = 8'h00;
    localparam logic [7:0] CTL3_RESET      = 8'h00;
    localparam logic [7:0] PIN_SEL_RESET   = 8'h00;
    localparam logic [7:0] READ_UNMAPPED   = 8'h00;
endpackage

/* test/acr_cpu_model.sv */
/*
 Processor model on the peripheral bus.
 Assumes one-cycle strobes taken at the rising edge.
*/
`timescale 1ns/10ps
module acr_cpu_model (
    // Clock
    input  wire logic       clock,
    // Peripheral bus
    output logic      [3:0] bus_addr,
    output logic            bus_rd,
    output logic            bus_wr,
    output logic      [7:0] bus_wdata,
    input  wire logic [7:0] bus_rdata
);
    initial begin
        bus_addr  = 4'h0;
        bus_rd    = 1'b0;
        bus_wr    = 1'b0;
        bus_wdata = 8'h00;
    end
    // Released lines show the inverse of the last value
    task wr(logic [3:0] a, logic [7:0] v);
        @(negedge clock);
        bus_addr  = a;
        bus_wdata = v;
        bus_wr    = 1'b1;
        @(negedge clock);
        bus_wr    = 1'b0;
        bus_addr  = ~a;
        bus_wdata = ~v;
    endtask
    task rd(logic [3:0] a, output logic [7:0] d);
        @(negedge clock);
        bus_addr = a;
        bus_rd   = 1'b1;
        @(negedge clock);
        bus_rd   = 1'b0;
        d        = bus_rdata;
        bus_addr = ~a;
    endtask
    // Results are used only once the end flag is seen
    task wait_eoc(output logic ok);
        logic [7:0] s;
        ok = 1'b0;
        for (int n = 0; n < 20 && !ok; n++) begin
            rd(acr_pkg::OFF_STATUS, s);
            ok = (s[0] === 1'b1);
        end
    endtask
endmodule

/* test/acr_top_asserts.sv */
/*
 Port-level checker for acr_top.
 Assumes one clock domain with synchronous reset.
*/
`timescale 1ns/10ps
module acr_top_asserts (
    // Clock and reset
    input wire logic       clock,
    input wire logic       reset,
    // Bus and chip state
    input wire logic [3:0] bus_addr,
    input wire logic       bus_rd,
    input wire logic       bus_wr,
    input wire logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    input wire logic       idle_mode,
    // Outputs
    input wire logic       core_abort,
    input wire logic [2:0] sample_delay_sel,
    input wire logic [7:0] analog_inputs_select,
    input wire logic [7:0] input_buffer_enable,
    input wire logic       internal_ref_on,
    input wire logic       irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    a_ref_off_disabled: assert property (core_abort |-> !internal_ref_on)
        else $error("reference on while disabled");
    a_irq_when_off: assert property (irq |-> !core_abort)
        else $error("interrupt while disabled");
    a_enable_write: assert property (bus_wr && bus_addr == acr_pkg::OFF_CONTROL_1 |=>
        core_abort == !$past(bus_wdata[0])) else $error("abort does not follow enable");
    a_ref_follow: assert property (bus_wr && bus_addr == acr_pkg::OFF_CONTROL_1 |=>
        internal_ref_on == ($past(bus_wdata[0]) && $past(bus_wdata[1]))) else $error("reference wrong");
    a_pin_select: assert property (bus_wr && bus_addr == acr_pkg::OFF_PIN_SELECT |=>
        analog_inputs_select == $past(bus_wdata)) else $error("pin select wrong");
    a_buffer_blocked: assert property (input_buffer_enable != 8'h00 |-> $past(bus_rd) &&
        $past(bus_addr) == acr_pkg::OFF_PORT_DATA && !$past(idle_mode)) else $error("buffer open");
    a_delay_field: assert property (bus_wr && bus_addr == acr_pkg::OFF_CONTROL_3 |=>
        sample_delay_sel == $past(bus_wdata[5:3])) else $error("delay field wrong");
    a_eoc_status: assert property (bus_rd && bus_addr == acr_pkg::OFF_STATUS && irq |=>
        bus_rdata[0]) else $error("status lacks end flag");
    a_buffer_opens: assert property (bus_rd && bus_addr == acr_pkg::OFF_PORT_DATA && !idle_mode |=>
        input_buffer_enable == ~$past(analog_inputs_select)) else $error("buffer not opened on port read");
endmodule
bind acr_top acr_top_asserts chk_u (.clock, .reset, .bus_addr, .bus_rd, .bus_wr, .bus_wdata, .bus_rdata,
    .idle_mode, .core_abort, .sample_delay_sel, .analog_inputs_select, .input_buffer_enable,
    .internal_ref_on, .irq);

/* test/testbench.sv */
/*
 Self-checking bench for acr_top.
 Assumes the processor model owns the bus; the bench drives the core side.
*/
`timescale 1ns/10ps
module testbench;
    logic       clock, reset, core_result_valid, core_done, core_buffer_full, core_busy, core_overflow;
    logic       idle_mode, bus_rd, bus_wr, core_abort, internal_ref_on, irq, ok;
    logic [7:0] core_result, digital_port_inputs, bus_wdata, bus_rdata, analog_inputs_select;
    logic [7:0] input_buffer_enable, d, s, res [4];
    logic [3:0] bus_addr;
    logic [2:0] sample_delay_sel;
    int         fail_count, total_checks;
    acr_top dut_u (.clock, .reset, .bus_addr, .bus_rd, .bus_wr, .bus_wdata, .bus_rdata, .core_result_valid,
        .core_result, .core_done, .core_buffer_full, .core_busy, .core_overflow, .core_abort, .sample_delay_sel,
        .idle_mode, .digital_port_inputs, .analog_inputs_select, .input_buffer_enable, .internal_ref_on, .irq);
    acr_cpu_model cpu_u (.clock, .bus_addr, .bus_rd, .bus_wr, .bus_wdata, .bus_rdata);
    task chk(string n, logic [7:0] e, logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    function logic [7:0] port_exp(logic [7:0] p, logic [7:0] sel);
        return p & ~sel;
    endfunction
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        end_of_test;
    end
    initial begin
        {reset, core_result_valid, core_done, core_buffer_full, core_busy, core_overflow, idle_mode} = 7'h40;
        core_result = 8'h00;
        digital_port_inputs = 8'h00;
        fail_count = 0;
        total_checks = 0;
        void'($urandom(32'he781));
        repeat (10) @(negedge clock);
        reset = 1'b0;
        chk("abort", 8'h01, {7'h00, core_abort});
        cpu_u.wr(acr_pkg::OFF_CONTROL_1, 8'h02);
        chk("ref", 8'h00, {7'h00, internal_ref_on});
        cpu_u.wr(acr_pkg::OFF_CONTROL_1, 8'h07);
        chk("ref", 8'h01, {7'h00, internal_ref_on});
        for (int i = 0; i < 4; i++) begin
            res[i] = 8'($urandom);
            @(negedge clock);
            core_result_valid = 1'b1;
            core_result = res[i];
            @(negedge clock);
            core_result_valid = 1'b0;
            core_result = ~res[i];
        end
        core_done = 1'b1;
        @(negedge clock);
        core_done = 1'b0;
        cpu_u.wait_eoc(ok);
        chk("eoc", 8'h01, {7'h00, ok});
        chk("irq", 8'h01, {7'h00, irq});
        cpu_u.wr(acr_pkg::OFF_RESULT_0, ~res[0]);
        for (int k = 0; k < 8; k++) begin
            if (k == 4) begin
                @(negedge clock);
                reset = 1'b1;
                @(negedge clock);
                reset = 1'b0;
            end
            cpu_u.rd(4'(k % 4), d);
            chk("result", res[k % 4], d);
        end
        cpu_u.wr(acr_pkg::OFF_CONTROL_1, 8'h01);
        chk("ref", 8'h00, {7'h00, internal_ref_on});
        core_done = 1'b1;
        @(negedge clock);
        core_done = 1'b0;
        cpu_u.rd(acr_pkg::OFF_STATUS, d);
        chk("status", 8'h01, d);
        chk("irq", 8'h00, {7'h00, irq});
        cpu_u.wr(acr_pkg::OFF_CONTROL_1, 8'h00);
        cpu_u.wr(acr_pkg::OFF_CONTROL_1, 8'h05);
        core_overflow = 1'b1;
        core_buffer_full = 1'b1;
        core_busy = 1'b1;
        @(negedge clock);
        core_overflow = 1'b0;
        core_buffer_full = 1'b0;
        cpu_u.rd(acr_pkg::OFF_STATUS, d);
        chk("status", 8'h07, d);
        chk("irq", 8'h01, {7'h00, irq});
        core_busy = 1'b0;
        cpu_u.wr(acr_pkg::OFF_CONTROL_1, 8'h00);
        cpu_u.rd(acr_pkg::OFF_STATUS, d);
        chk("status", 8'h00, d);
        chk("irq", 8'h00, {7'h00, irq});
        for (int k = 0; k < 6; k++) begin
            s = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
            digital_port_inputs = 8'($urandom);
            idle_mode = k[0];
            cpu_u.wr(acr_pkg::OFF_PIN_SELECT, s);
            chk("select", s, analog_inputs_select);
            cpu_u.rd(acr_pkg::OFF_PORT_DATA, d);
            if (!k[0]) chk("port", port_exp(digital_port_inputs, s), d);
            chk("bufen", k[0] ? 8'h00 : ~s, input_buffer_enable);
        end
        s = 8'($urandom) & 8'h3f;
        if (s[5:3] == 3'h7) s[5:3] = 3'h6;
        cpu_u.wr(acr_pkg::OFF_CONTROL_3, s);
        chk("delay", {5'h00, s[5:3]}, {5'h00, sample_delay_sel});
        cpu_u.rd(4'hf, d);
        chk("unmapped", 8'h00, d);
        end_of_test;
    end
endmodule
